// ===== src/conv_seq_pkg.sv
package conv_seq_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned TON_MS  [4] = '{1, 2, 4, 8};          // turn-on delay choices
  localparam int unsigned LL_MS   [4] = '{100, 500, 1000, 2000}; // light-load timeouts
  localparam int unsigned RAMP_MS [2] = '{1, 4};                 // ramp time choices
  localparam int unsigned RETRY_MS    = 3000;                    // overload retry off time
  localparam int unsigned WDOG_MS [3] = '{500, 1000, 2000};      // watchdog periods 1..3
  localparam int unsigned OC_SHORT = 8;
  localparam int unsigned OC_LONG  = 16;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] TIMING_OFS = 8'h04;
  localparam logic [7:0] UV_OFS     = 8'h08;
  localparam logic [7:0] WDOG_OFS   = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam int unsigned WDOG_KICK_BIT = 8;
  localparam logic [7:0] UV_BASE_RST = 8'h80;
  localparam logic [7:0] UV_STEP_RST = 8'h10;

  typedef struct packed {
    logic       ramp_long;      // [5]
    logic       en_active_low;  // [4]
    logic       oc_long;        // [3]
    logic       ldo_fault_mask; // [2]
    logic       force_on_bit;   // [1]
    logic       standby_hold;   // [0]
  } ctrl_t;

  // ****************************************
  // analog comparator inputs
  // ****************************************
  typedef struct packed {
    logic [7:0] vin_code;       // input voltage measurement
    logic       vin_ok;         // input above start threshold
    logic       vin_ov;         // input above overvoltage level
    logic       ldo_fault;      // ldo fault incl. timeout
    logic       hot_trip;       // die above shutdown temperature
    logic       hot_warm;       // die still within hysteresis band
    logic       oc_hit;         // cycle hit current limit
    logic       sw_cycle;       // one pulse per switching cycle
    logic       out_low;        // output below collapse level
    logic       out_in_reg;     // output in regulation
    logic       light_load;     // light load detected
    logic       buck_mode;      // power stage in buck topology
  } sense_t;

  typedef enum logic [1:0] {MODE_RESET, MODE_STANDBY, MODE_POWER} mode_t;
  typedef enum logic [2:0] {SUB_IDLE, SUB_RAMP, SUB_STEADY, SUB_LLOFF, SUB_RETRY} sub_t;

endpackage

// ===== src/converter_mode_fault_sequencer.sv
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - top mode machine has exactly reset, standby and power-on states
// - power-up enters reset with defaults; host interface dead in reset
// - reset goes to standby once input is above start threshold
// - standby keeps converter off while host interface and config stay usable
// - standby-hold register beats the enable pin and holds standby
// - standby goes to power-on on enable pin or force-on bit
// - each power-on entry starts sub-machine idle with converter off
// - faults clear then turn-on delay from 2-bit select, then ramp
// - undervoltage fault while input below base minus step, self clears
// - ldo fault returns to idle like the other faults, self clears, maskable by mask bit
// - watchdog fault on expiry; kick or zero period clears it
// - overcurrent latch after 8 or 16 limit cycles; cleared leaving to standby
// - overvoltage fault while input too high, self clears
// - overheat fault unmaskable with hysteresis, blocks idle exit
// - ramp enables converter for selected time, then steady when regulated
// - any fault during ramp returns to idle, converter off
// - any fault during steady returns to idle, converter off
// - output collapse in steady enters overload retry
// - light load longer than selected timeout enters low-load off
// - low-load off only entered in buck topology
// - low-load off left only by leaving power-on
// - overload retry holds converter off 3 s then restarts from idle
// - enable pin polarity option, active high by default
// - output-good driven low only when enabled and output valid
module converter_mode_fault_sequencer
  import conv_seq_pkg::*;
#(
  parameter int unsigned ADDR_W        = 8,
  parameter bit          EN_ACTIVE_LOW = 1'b0,
  parameter int unsigned TON_CYC  [4]  = '{TON_MS[0]*CYC_PER_MS, TON_MS[1]*CYC_PER_MS,
                                           TON_MS[2]*CYC_PER_MS, TON_MS[3]*CYC_PER_MS},
  parameter int unsigned LL_CYC   [4]  = '{LL_MS[0]*CYC_PER_MS, LL_MS[1]*CYC_PER_MS,
                                           LL_MS[2]*CYC_PER_MS, LL_MS[3]*CYC_PER_MS},
  parameter int unsigned RAMP_CYC [2]  = '{RAMP_MS[0]*CYC_PER_MS, RAMP_MS[1]*CYC_PER_MS},
  parameter int unsigned RETRY_CYC     = RETRY_MS*CYC_PER_MS,
  parameter int unsigned WDOG_CYC [3]  = '{WDOG_MS[0]*CYC_PER_MS, WDOG_MS[1]*CYC_PER_MS,
                                           WDOG_MS[2]*CYC_PER_MS}
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              en_pin,
  input  wire sense_t            sense,
  output logic                   conv_en,
  output logic                   host_if_active,
  output logic                   output_good_o,
  output logic                   output_good_oe
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (ADDR_W < 5) begin : g_bad_addr
    $error("address width too small for register map");
  end
  if (RETRY_CYC == 0) begin : g_bad_retry
    $error("retry count must be at least one cycle");
  end
  // a zero count would wrap the minus-one compare and stall the timer
  if (TON_CYC[0] == 0 || TON_CYC[1] == 0 || TON_CYC[2] == 0 || TON_CYC[3] == 0 ||
      RAMP_CYC[0] == 0 || RAMP_CYC[1] == 0) begin : g_bad_delay
    $error("turn-on and ramp counts must be at least one cycle");
  end
  if (LL_CYC[0] == 0 || LL_CYC[1] == 0 || LL_CYC[2] == 0 || LL_CYC[3] == 0 ||
      WDOG_CYC[0] == 0 || WDOG_CYC[1] == 0 || WDOG_CYC[2] == 0) begin : g_bad_timeout
    $error("light-load and watchdog counts must be at least one cycle");
  end

  // ****************************************
  // state and registers
  // ****************************************
  mode_t       mode_r;
  sub_t        sub_r;
  ctrl_t       ctrl_r;
  logic [1:0]  ton_sel_r;
  logic [1:0]  ll_sel_r;
  logic [7:0]  uv_base_r;
  logic [7:0]  uv_step_r;
  logic [1:0]  wdog_per_r;
  logic [31:0] tmr_r;
  logic [31:0] wdog_cnt_r;
  logic [4:0]  oc_cnt_r;
  logic        uv_r;
  logic        ov_r;
  logic        ldo_r;
  logic        wdog_r;
  logic        oc_latch_r;
  logic        hot_r;
  logic        conv_en_r;
  logic        good_r;
  logic [31:0] prdata_r;

  logic        wr_en;
  logic        mapped;
  logic        kick;
  logic        en_active;
  logic        want_on;
  logic        leave_on;
  logic        fault_any;

  // undervoltage compare against base minus step, no underflow
  function automatic logic uv_below(input logic [7:0] code, input logic [7:0] base,
                                    input logic [7:0] step);
    uv_below = (step <= base) && (code < (base - step));
  endfunction

  // address decode
  function automatic logic is_reg(input logic [ADDR_W-1:0] a);
    is_reg = (a == ADDR_W'(CTRL_OFS)) || (a == ADDR_W'(TIMING_OFS)) ||
             (a == ADDR_W'(UV_OFS)) || (a == ADDR_W'(WDOG_OFS)) ||
             (a == ADDR_W'(STATUS_OFS));
  endfunction

  // ****************************************
  // apb slave
  // ****************************************
  assign mapped  = is_reg(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (!mapped || mode_r == MODE_RESET);
  assign wr_en   = psel && penable && pwrite && mapped && mode_r != MODE_RESET;
  assign kick    = wr_en && paddr == ADDR_W'(WDOG_OFS) && pwdata[WDOG_KICK_BIT];
  assign prdata  = prdata_r;
  assign host_if_active = (mode_r != MODE_RESET);

  // config writes, live in standby and power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= '{ramp_long: 1'b0, en_active_low: EN_ACTIVE_LOW, oc_long: 1'b0,
                      ldo_fault_mask: 1'b0, force_on_bit: 1'b0, standby_hold: 1'b0};
      ton_sel_r  <= 2'h0;
      ll_sel_r   <= 2'h0;
      uv_base_r  <= UV_BASE_RST;
      uv_step_r  <= UV_STEP_RST;
      wdog_per_r <= 2'h0;
    end else if (wr_en) begin
      unique case (paddr)
        ADDR_W'(CTRL_OFS):   ctrl_r     <= ctrl_t'(pwdata[5:0]);
        ADDR_W'(TIMING_OFS): begin
          ton_sel_r <= pwdata[1:0];
          ll_sel_r  <= pwdata[3:2];
        end
        ADDR_W'(UV_OFS): begin
          uv_base_r <= pwdata[7:0];
          uv_step_r <= pwdata[15:8];
        end
        ADDR_W'(WDOG_OFS):   wdog_per_r <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // read data captured in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_r <= 32'h0000_0000;
      if (mode_r != MODE_RESET) begin
        unique case (paddr)
          ADDR_W'(CTRL_OFS):   prdata_r <= {26'h0, ctrl_r};
          ADDR_W'(TIMING_OFS): prdata_r <= {28'h0, ll_sel_r, ton_sel_r};
          ADDR_W'(UV_OFS):     prdata_r <= {16'h0, uv_step_r, uv_base_r};
          ADDR_W'(WDOG_OFS):   prdata_r <= {30'h0, wdog_per_r};
          ADDR_W'(STATUS_OFS): prdata_r <= {20'h0, conv_en_r, hot_r, oc_latch_r, wdog_r,
                                            ldo_r, ov_r, uv_r, sub_r, mode_r};
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // fault detection
  // ****************************************
  // self-clearing level faults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_r  <= 1'b0;
      ov_r  <= 1'b0;
      ldo_r <= 1'b0;
    end else begin
      uv_r  <= uv_below(sense.vin_code, uv_base_r, uv_step_r);
      ov_r  <= sense.vin_ov;
      ldo_r <= sense.ldo_fault;
    end
  end

  // overheat with hysteresis, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hot_r <= 1'b0;
    end else if (sense.hot_trip) begin
      hot_r <= 1'b1;
    end else if (!sense.hot_warm) begin
      hot_r <= 1'b0;
    end
  end

  // watchdog counter and fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_cnt_r <= 32'h0000_0000;
      wdog_r     <= 1'b0;
    end else if (wdog_per_r == 2'h0) begin
      wdog_cnt_r <= 32'h0000_0000;
      wdog_r     <= 1'b0;
    end else if (wdog_cnt_r >= WDOG_CYC[wdog_per_r - 2'h1] - 1) begin
      wdog_cnt_r <= 32'h0000_0000;
      wdog_r     <= 1'b1;
    end else if (kick) begin
      wdog_cnt_r <= 32'h0000_0000;
      wdog_r     <= 1'b0;
    end else begin
      wdog_cnt_r <= wdog_cnt_r + 32'h0000_0001;
    end
  end

  // consecutive limit cycles and overcurrent latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_cnt_r   <= 5'h00;
      oc_latch_r <= 1'b0;
    end else begin
      if (sense.sw_cycle && mode_r == MODE_POWER) begin
        oc_cnt_r <= sense.oc_hit ? (oc_cnt_r == 5'h1F ? oc_cnt_r : oc_cnt_r + 5'h01) : 5'h00;
      end
      if (sense.sw_cycle && sense.oc_hit && mode_r == MODE_POWER &&
          32'(oc_cnt_r) + 1 >= (ctrl_r.oc_long ? OC_LONG : OC_SHORT)) begin
        oc_latch_r <= 1'b1;
      end else if (mode_r == MODE_POWER && leave_on) begin
        oc_latch_r <= 1'b0;
        oc_cnt_r   <= 5'h00;
      end
    end
  end

  assign fault_any = uv_r || ov_r || (ldo_r && !ctrl_r.ldo_fault_mask) || wdog_r ||
                     oc_latch_r || hot_r;

  // ****************************************
  // top mode machine
  // ****************************************
  assign en_active = en_pin ^ ctrl_r.en_active_low;
  assign want_on   = !ctrl_r.standby_hold && (en_active || ctrl_r.force_on_bit);
  assign leave_on  = !want_on;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= MODE_RESET;
    end else begin
      unique case (mode_r)
        MODE_RESET:   if (sense.vin_ok) mode_r <= MODE_STANDBY;
        MODE_STANDBY: if (want_on) mode_r <= MODE_POWER;
        MODE_POWER:   if (leave_on) mode_r <= MODE_STANDBY;
        default:      mode_r <= MODE_RESET;
      endcase
    end
  end

  // ****************************************
  // power-on sub-machine and shared timer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_r <= SUB_IDLE;
      tmr_r <= 32'h0000_0000;
    end else if (mode_r != MODE_POWER || leave_on) begin
      sub_r <= SUB_IDLE;
      tmr_r <= 32'h0000_0000;
    end else begin
      tmr_r <= tmr_r + 32'h0000_0001;
      unique case (sub_r)
        SUB_IDLE: begin
          if (fault_any) begin
            tmr_r <= 32'h0000_0000;
          end else if (tmr_r >= TON_CYC[ton_sel_r] - 1) begin
            sub_r <= SUB_RAMP;
            tmr_r <= 32'h0000_0000;
          end
        end
        SUB_RAMP: begin
          if (fault_any) begin
            sub_r <= SUB_IDLE;
            tmr_r <= 32'h0000_0000;
          end else if (tmr_r >= RAMP_CYC[ctrl_r.ramp_long] - 1 && sense.out_in_reg) begin
            sub_r <= SUB_STEADY;
            tmr_r <= 32'h0000_0000;
          end else if (tmr_r >= RAMP_CYC[ctrl_r.ramp_long] - 1) begin
            tmr_r <= tmr_r;
          end
        end
        SUB_STEADY: begin
          if (fault_any) begin
            sub_r <= SUB_IDLE;
            tmr_r <= 32'h0000_0000;
          end else if (sense.out_low) begin
            sub_r <= SUB_RETRY;
            tmr_r <= 32'h0000_0000;
          end else if (!(sense.light_load && sense.buck_mode)) begin
            tmr_r <= 32'h0000_0000;
          end else if (tmr_r >= LL_CYC[ll_sel_r] - 1) begin
            sub_r <= SUB_LLOFF;
            tmr_r <= 32'h0000_0000;
          end
        end
        SUB_LLOFF: tmr_r <= 32'h0000_0000;
        SUB_RETRY: begin
          if (tmr_r >= RETRY_CYC - 1) begin
            sub_r <= SUB_IDLE;
            tmr_r <= 32'h0000_0000;
          end
        end
        default: sub_r <= SUB_IDLE;
      endcase
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // converter enable and output-good follow state one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_en_r <= 1'b0;
      good_r    <= 1'b0;
    end else begin
      conv_en_r <= mode_r == MODE_POWER &&
                   (sub_r == SUB_RAMP || sub_r == SUB_STEADY);
      good_r    <= mode_r == MODE_POWER && sub_r == SUB_STEADY && !fault_any;
    end
  end

  assign conv_en        = conv_en_r;
  assign output_good_o  = 1'b0; // open drain, only pulls low
  assign output_good_oe = good_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RESET_EXIT: assert property (mode_r == MODE_RESET && sense.vin_ok |=>
    mode_r == MODE_STANDBY) else $error("reset did not leave for standby");
  AST_NO_HOST_IN_RESET: assert property (mode_r == MODE_RESET |-> !wr_en &&
    !host_if_active) else $error("host interface live in reset");
  AST_HOLD_WINS: assert property (mode_r == MODE_STANDBY && ctrl_r.standby_hold |=>
    mode_r == MODE_STANDBY) else $error("standby-hold ignored");
  AST_TURN_ON: assert property (mode_r == MODE_STANDBY && want_on |=>
    mode_r == MODE_POWER) else $error("standby did not start power-on");
  AST_ENTRY_IDLE: assert property ($rose(mode_r == MODE_POWER) |->
    sub_r == SUB_IDLE) else $error("sub-machine not idle at entry");
  AST_OFF_OUTSIDE: assert property (mode_r != MODE_POWER |=> !conv_en)
    else $error("converter on outside power-on");
  AST_RAMP_FAULT: assert property (mode_r == MODE_POWER && !leave_on &&
    sub_r == SUB_RAMP && fault_any |=> sub_r == SUB_IDLE ##1 !conv_en)
    else $error("ramp fault did not return to idle");
  AST_COLLAPSE: assert property (mode_r == MODE_POWER && !leave_on &&
    sub_r == SUB_STEADY && !fault_any && sense.out_low |=> sub_r == SUB_RETRY)
    else $error("collapse did not enter retry");
  AST_LL_BUCK: assert property ($rose(sub_r == SUB_LLOFF) |->
    $past(sense.buck_mode)) else $error("low-load off outside buck");
  AST_LL_STAY: assert property (sub_r == SUB_LLOFF && mode_r == MODE_POWER &&
    !leave_on |=> sub_r == SUB_LLOFF) else $error("left low-load off inside power-on");
  AST_OC_KEEP: assert property (oc_latch_r && !(mode_r == MODE_POWER && leave_on) |=>
    oc_latch_r) else $error("overcurrent latch dropped");
  AST_GOOD: assert property (output_good_oe |-> conv_en && !output_good_o)
    else $error("output-good without enabled converter");
  AST_LEAVE: assert property (mode_r == MODE_POWER && leave_on |=>
    mode_r == MODE_STANDBY && sub_r == SUB_IDLE) else $error("power-on exit failed");

  COV_STEADY: cover property (mode_r == MODE_POWER && sub_r == SUB_STEADY);
  COV_RETRY:  cover property (sub_r == SUB_RETRY ##1 sub_r == SUB_IDLE);
  COV_LLOFF:  cover property ($rose(sub_r == SUB_LLOFF));
  COV_OC:     cover property ($rose(oc_latch_r));

endmodule

// ===== verif/analog_stage_model.sv
`timescale 1ns/1ps
// ****************************************
// comparator front end of the power stage
// ****************************************
module analog_stage_model
  import conv_seq_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic [7:0] vin_dv,
  input  wire logic [7:0] out_dv,
  input  wire logic [7:0] temp_c,
  input  wire logic [3:0] flags,
  output sense_t          sense
);
  logic [1:0] cyc_r = 2'h0;

  // switching cycle counter, one pulse every four clocks
  always_ff @(posedge pclk) begin
    cyc_r <= cyc_r + 2'h1;
  end

  // voltages in tenths of a volt, die temperature in degrees
  // flags: ldo fault, current limit hit, light load, buck topology
  assign sense = '{
    vin_code:   vin_dv,
    vin_ok:     vin_dv > 8'h27,
    vin_ov:     vin_dv > 8'hEB,
    ldo_fault:  flags[3],
    hot_trip:   temp_c > 8'hA0,
    hot_warm:   temp_c > 8'h82,
    oc_hit:     flags[2],
    sw_cycle:   cyc_r == 2'h3,
    out_low:    out_dv < 8'h1E,
    out_in_reg: out_dv > 8'h2D,
    light_load: flags[1],
    buck_mode:  flags[0]
  };
endmodule

// ===== verif/tb_converter_mode_fault_sequencer.sv
`timescale 1ns/1ps
module tb_converter_mode_fault_sequencer
  import conv_seq_pkg::*;
;
  localparam int RETRY = 30;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, vin_dv, out_dv, temp_c;
  logic [31:0] pwdata, prdata, v;
  logic [3:0]  flags;
  logic        en_pin, conv_en, host_if_active, output_good_o, output_good_oe;
  sense_t      sense;
  int          fails, check_count;

  // ****************************************
  // clock, design and far side
  // ****************************************
  always #20 pclk = ~pclk;

  converter_mode_fault_sequencer #(
    .TON_CYC('{4, 6, 8, 12}), .LL_CYC('{10, 12, 14, 16}), .RAMP_CYC('{4, 8}),
    .RETRY_CYC(RETRY), .WDOG_CYC('{20, 30, 40})
  ) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .en_pin(en_pin), .sense(sense), .conv_en(conv_en), .host_if_active(host_if_active),
    .output_good_o(output_good_o), .output_good_oe(output_good_oe)
  );

  analog_stage_model far_side (
    .pclk(pclk), .vin_dv(vin_dv), .out_dv(out_dv), .temp_c(temp_c), .flags(flags),
    .sense(sense)
  );

  // ****************************************
  // bus and check tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // one setup cycle, access held until pready, then an idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, v, er);
  endtask

  // poll status until the masked value matches, bounded
  task automatic wait_st(input string n, input logic [31:0] m, input logic [31:0] e,
                         input int lim);
    for (int i = 0; i < lim; i++) begin
      apb(1'b0, STATUS_OFS, 32'h0, v, er);
      if ((v & m) === e) break;
    end
    chk(n, e, v & m);
  endtask

  task automatic results;
    if (fails == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog against a hung run
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    results();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; en_pin = 1'b0; vin_dv = 8'h1E; out_dv = 8'h00; temp_c = 8'h19;
    flags = 4'h0; fails = 0; check_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    chk("host_if_active", 32'h0, {31'h0, host_if_active});
    apb(1'b0, UV_OFS, 32'h0, v, er);
    chk("reset access err", 32'h1, {31'h0, er});
    chk("reset read", 32'h0, v);
    vin_dv <= 8'h78;
    wait_st("to standby", 32'h3, 32'h1, 5);
    chk("host_if_active on", 32'h1, {31'h0, host_if_active});
    apb(1'b0, UV_OFS, 32'h0, v, er);
    chk("uv default", 32'h1080, v);
    wr(TIMING_OFS, 32'h3);
    apb(1'b0, TIMING_OFS, 32'h0, v, er);
    chk("timing write", 32'h3, v);
    chk("conv_en standby", 32'h0, {31'h0, conv_en});
    wr(CTRL_OFS, 32'h1);
    en_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    wait_st("hold standby", 32'h1F, 32'h01, 1);
    wr(CTRL_OFS, 32'h0);
    wait_st("enter idle", 32'h1F, 32'h02, 1);
    repeat (5) @(posedge pclk);
    wait_st("delay idle", 32'h1F, 32'h02, 1);
    out_dv <= 8'h32;
    wait_st("ramp", 32'h1F, 32'h06, 10);
    chk("conv_en ramp", 32'h1, {31'h0, conv_en});
    wait_st("steady", 32'h1F, 32'h0A, 10);
    chk("good steady", 32'h1, {31'h0, output_good_oe});
    chk("good pin level", 32'h0, {31'h0, output_good_o});
    chk("pready", 32'h1, {31'h0, pready});
    flags <= 4'h2;
    repeat (30) @(posedge pclk);
    wait_st("no lloff boost", 32'h1F, 32'h0A, 1);
    flags <= 4'h3;
    wait_st("lloff", 32'h1F, 32'h0E, 10);
    chk("conv_en lloff", 32'h0, {31'h0, conv_en});
    chk("good lloff", 32'h0, {31'h0, output_good_oe});
    flags <= 4'h0;
    repeat (10) @(posedge pclk);
    wait_st("stay lloff", 32'h1F, 32'h0E, 1);
    en_pin <= 1'b0;
    wait_st("leave power", 32'h1F, 32'h01, 2);
    // undervoltage below 0x80 minus 0x10, then overvoltage in ramp
    vin_dv <= 8'h64;
    out_dv <= 8'h28;
    en_pin <= 1'b1;
    repeat (20) @(posedge pclk);
    wait_st("uv hold", 32'h3F, 32'h22, 4);
    vin_dv <= 8'h78;
    wait_st("uv clear ramp", 32'h3F, 32'h06, 12);
    vin_dv <= 8'hF0;
    wait_st("ov idle", 32'h5F, 32'h42, 3);
    chk("conv_en ov", 32'h0, {31'h0, conv_en});
    vin_dv <= 8'h78;
    out_dv <= 8'h32;
    wait_st("ov clear", 32'h5F, 32'h0A, 14);
    flags <= 4'h8;
    wait_st("ldo idle", 32'h9F, 32'h82, 3);
    wr(CTRL_OFS, 32'h24);
    wait_st("ldo masked", 32'h1F, 32'h0A, 14);
    flags <= 4'h0;
    wr(CTRL_OFS, 32'h0);
    out_dv <= 8'h14;
    wait_st("retry", 32'h1F, 32'h12, 3);
    chk("conv_en retry", 32'h0, {31'h0, conv_en});
    repeat (RETRY - 12) @(posedge pclk);
    wait_st("retry hold", 32'h1F, 32'h12, 1);
    wait_st("retry idle", 32'h1F, 32'h02, 8);
    out_dv <= 8'h32;
    wait_st("restart", 32'h1F, 32'h0A, 14);
    wr(CTRL_OFS, 32'h8);
    flags <= 4'h4;
    repeat (40) @(posedge pclk);
    wait_st("oc long wait", 32'h21F, 32'h00A, 1);
    wait_st("oc latch", 32'h21F, 32'h202, 30);
    flags <= 4'h0;
    repeat (20) @(posedge pclk);
    wait_st("oc held", 32'h21F, 32'h202, 1);
    en_pin <= 1'b0;
    wait_st("oc cleared", 32'h203, 32'h1, 3);
    // die temperature with hysteresis, then watchdog
    temp_c <= 8'hAA;
    wait_st("hot set", 32'h400, 32'h400, 3);
    temp_c <= 8'h8C;
    repeat (5) @(posedge pclk);
    wait_st("hot band", 32'h400, 32'h400, 1);
    temp_c <= 8'h78;
    wait_st("hot clear", 32'h400, 32'h0, 3);
    wr(WDOG_OFS, 32'h1);
    wait_st("wdog set", 32'h100, 32'h100, 12);
    wr(WDOG_OFS, 32'h101);
    wait_st("wdog kick", 32'h100, 32'h0, 1);
    wait_st("wdog again", 32'h100, 32'h100, 12);
    wr(WDOG_OFS, 32'h0);
    repeat (30) @(posedge pclk);
    wait_st("wdog off", 32'h100, 32'h0, 1);
    wr(CTRL_OFS, 32'h10);
    wait_st("active low on", 32'h3, 32'h2, 3);
    en_pin <= 1'b1;
    wait_st("active low off", 32'h3, 32'h1, 3);
    wr(CTRL_OFS, 32'h12);
    wait_st("force on", 32'h3, 32'h2, 3);
    wr(CTRL_OFS, 32'h13);
    wait_st("hold beats force", 32'h3, 32'h1, 3);
    apb(1'b0, 8'h40, 32'h0, v, er);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, v);
    results();
  end
endmodule
